// ==== bfsm_host_model.sv ====
/*
   Management host model: drives the two-wire link clock and pulls the data wire low.
   Assumes the bench forms the wire level from both pull-downs and a pull-up.
*/
module bfsm_host_model #(
   parameter int HALF = 4
) (
   // Clock and wire level
   input  wire logic clk,
   input  wire logic sda_lvl,
   // Host drive
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   // Released wire rises to the pull-up level, never keeps the last bit
   initial
   begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Data moves one clk after the link clock falls, never while it is high
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_low = ~b[i];
         hold(HALF);
         scl = 1'b1;
         hold(HALF);
         scl = 1'b0;
         hold(1);
      end
      sda_low = 1'b0;
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
      ack = ~sda_lvl;
      scl = 1'b0;
      hold(1);
   endtask

   task automatic write_frame(input logic [7:0] addr, input logic [7:0] cmd, input logic [15:0] val,
                              output logic [3:0] acks);
      sda_low = 1'b0;
      scl     = 1'b1;
      hold(HALF);
      sda_low = 1'b1;
      hold(HALF);
      scl = 1'b0;
      hold(1);
      put_byte(addr, acks[3]);
      put_byte(cmd, acks[2]);
      put_byte(val[15:8], acks[1]);
      put_byte(val[7:0], acks[0]);
      sda_low = 1'b1;
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
      sda_low = 1'b0;
      hold(HALF);
   endtask
endmodule // bfsm_host_model

// ==== bfsm_limit_cmp.sv ====
/*
   One threshold comparator of the shutdown monitor. Assumes the reading and the
   limit are synchronous to clk and the reading is qualified by its strobe.
*/
module bfsm_limit_cmp #(
   parameter bit TRIP_BELOW = 1'b0
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic                          ce,
   // Reading and limit
   input  wire logic                          sample_valid,
   input  wire logic [bfsm_pkg::DATA_W-1:0]   reading,
   input  wire logic [bfsm_pkg::DATA_W-1:0]   limit,
   // Result
   output logic                               trip
);
   logic trip_r;
   logic trip_nxt;

   // R2: nonrecoverable compare only
   always_comb
   begin
      trip_nxt = 1'b0;
      if (sample_valid)
      begin
         if (TRIP_BELOW)
            trip_nxt = (reading < limit);
         else
            trip_nxt = (reading >= limit);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         trip_r <= 1'b0;
      else if (ce)
         trip_r <= trip_nxt;
   end

   assign trip = trip_r;
endmodule // bfsm_limit_cmp

// ==== bfsm_pkg.sv ====
/*
   Constants shared by the board fault shutdown monitor: thresholds, link address,
   command codes and timing. Assumes a 100 MHz clock and readings given in
   millivolts and whole degrees Celsius.
*/
// Summary of operation
// R1: Threshold hit removes power, requests host reboot
// R2: Only the nonrecoverable limits trip shutdown
// R3: Default trip: supply below 10.46 volts
// R4: Default trip: junction temperature at 100 C
// R5: Host rewrites limits; new limits used afterwards
// R6: Answers as link target at address 0xce
// R7: Green steady while initialising, blinking when running
// R8: Red steady while fault holds power off
// R9: Exactly one indicator selected at any time
// R10: Fault and power hold-off latched until reset
package bfsm_pkg;
   localparam int          DATA_W          = 16;
   // Limits in millivolts and degrees Celsius
   localparam logic [15:0] VOLT_LIMIT_MV   = 16'h28dc;   // 10460 mV
   localparam logic [15:0] TEMP_LIMIT_C    = 16'h0064;   // 100 C
   // Link target address byte and command codes
   localparam logic [7:0]  TARGET_ADDR     = 8'hce;
   localparam logic [7:0]  CMD_SET_VOLT    = 8'h01;
   localparam logic [7:0]  CMD_SET_TEMP    = 8'h02;
   localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
   localparam logic [1:0]  IDX_ADDR        = 2'h0;
   localparam logic [1:0]  IDX_CMD         = 2'h1;
   localparam logic [1:0]  IDX_HI          = 2'h2;
   localparam logic [1:0]  IDX_LO          = 2'h3;
   // Timing
   localparam int          CLK_MHZ         = 100;
   localparam int          INIT_TIME_US    = 1000;
   localparam int          BLINK_HALF_MS   = 250;
   localparam int          INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
   localparam int          BLINK_CYCLES    = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam int          CNT_W           = 27;

   typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_FAULT} bfsm_mode_e;
   typedef enum logic [1:0] {LK_IDLE, LK_BYTE, LK_ACK, LK_SKIP} bfsm_link_e;
endpackage

// ==== bfsm_top.sv ====
/*
   Board fault shutdown monitor: watches supply voltage and junction temperature,
   latches a fault that removes board power and asks the host to reboot, drives
   the status LEDs and takes new limits from the host over a two-wire link.
   Assumes link pins are already synchronous to clk and that the host runs the
   link clock far slower than clk.
*/
module bfsm_top #(
   parameter int unsigned INIT_CYCLES  = bfsm_pkg::INIT_CYCLES,
   parameter int unsigned BLINK_CYCLES = bfsm_pkg::BLINK_CYCLES
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic                          ce,
   // Sensor readings
   input  wire logic                          volt_valid,
   input  wire logic [bfsm_pkg::DATA_W-1:0]   volt_mv,
   input  wire logic                          temp_valid,
   input  wire logic [bfsm_pkg::DATA_W-1:0]   temp_c,
   // Management link
   input  wire logic                          scl,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe,
   // Board control and indicators
   output logic                               board_pwr_en,
   output logic                               host_reboot_req,
   output logic                               led_green,
   output logic                               led_red
);
   localparam int CNT_W = bfsm_pkg::CNT_W;

   // Link state
   bfsm_pkg::bfsm_link_e                link_r,  link_nxt;
   logic                                scl_d_r, scl_d_nxt;
   logic                                sda_d_r, sda_d_nxt;
   logic [7:0]                          shift_r, shift_nxt;
   logic [3:0]                          bcnt_r,  bcnt_nxt;
   logic [1:0]                          idx_r,   idx_nxt;
   logic [7:0]                          cmd_r,   cmd_nxt;
   logic [7:0]                          hi_r,    hi_nxt;
   logic                                oe_r,    oe_nxt;
   logic [bfsm_pkg::DATA_W-1:0]         vlim_r,  vlim_nxt;
   logic [bfsm_pkg::DATA_W-1:0]         tlim_r,  tlim_nxt;
   logic                                scl_rise, scl_fall, start_c, stop_c;

   // Monitor state
   bfsm_pkg::bfsm_mode_e                mode_r,  mode_nxt;
   logic [bfsm_pkg::CNT_W-1:0]          cnt_r,   cnt_nxt;
   logic                                blink_r, blink_nxt;
   logic                                reboot_r, reboot_nxt;
   logic                                volt_trip, temp_trip;

   assign scl_rise = scl & ~scl_d_r;
   assign scl_fall = ~scl & scl_d_r;
   assign start_c  = scl & scl_d_r & sda_d_r & ~sda_in;
   assign stop_c   = scl & scl_d_r & ~sda_d_r & sda_in;

   always_comb
   begin
      link_nxt  = link_r;
      scl_d_nxt = scl;
      sda_d_nxt = sda_in;
      shift_nxt = shift_r;
      bcnt_nxt  = bcnt_r;
      idx_nxt   = idx_r;
      cmd_nxt   = cmd_r;
      hi_nxt    = hi_r;
      oe_nxt    = oe_r;
      vlim_nxt  = vlim_r;
      tlim_nxt  = tlim_r;
      if (stop_c)
      begin
         link_nxt = bfsm_pkg::LK_IDLE;
         oe_nxt   = 1'b0;
      end
      else if (start_c)
      begin
         link_nxt = bfsm_pkg::LK_BYTE;
         bcnt_nxt = '0;
         idx_nxt  = bfsm_pkg::IDX_ADDR;
         oe_nxt   = 1'b0;
      end
      else
      begin
         unique case (link_r)
            bfsm_pkg::LK_IDLE,
            bfsm_pkg::LK_SKIP:
            begin
               oe_nxt = 1'b0;
            end
            bfsm_pkg::LK_BYTE:
            begin
               if (scl_rise && bcnt_r != bfsm_pkg::BITS_PER_BYTE)
               begin
                  shift_nxt = {shift_r[6:0], sda_in};
                  bcnt_nxt  = bcnt_r + 4'h1;
               end
               else if (scl_fall && bcnt_r == bfsm_pkg::BITS_PER_BYTE)
               begin
                  // Bytes we do not want are left unacknowledged
                  link_nxt = bfsm_pkg::LK_SKIP;
                  unique case (idx_r)
                     // R6: own address only
                     bfsm_pkg::IDX_ADDR:
                     begin
                        if (shift_r == bfsm_pkg::TARGET_ADDR)
                        begin
                           link_nxt = bfsm_pkg::LK_ACK;
                           oe_nxt   = 1'b1;
                        end
                     end
                     bfsm_pkg::IDX_CMD:
                     begin
                        if (shift_r == bfsm_pkg::CMD_SET_VOLT || shift_r == bfsm_pkg::CMD_SET_TEMP)
                        begin
                           cmd_nxt  = shift_r;
                           link_nxt = bfsm_pkg::LK_ACK;
                           oe_nxt   = 1'b1;
                        end
                     end
                     bfsm_pkg::IDX_HI:
                     begin
                        hi_nxt   = shift_r;
                        link_nxt = bfsm_pkg::LK_ACK;
                        oe_nxt   = 1'b1;
                     end
                     bfsm_pkg::IDX_LO:
                     begin
                        link_nxt = bfsm_pkg::LK_ACK;
                        oe_nxt   = 1'b1;
                        // R5: new limit replaces default
                        if (cmd_r == bfsm_pkg::CMD_SET_VOLT)
                           vlim_nxt = {hi_r, shift_r};
                        else
                           tlim_nxt = {hi_r, shift_r};
                     end
                  endcase
               end
            end
            bfsm_pkg::LK_ACK:
            begin
               if (scl_fall)
               begin
                  oe_nxt   = 1'b0;
                  bcnt_nxt = '0;
                  // A fifth byte in one frame is not taken
                  if (idx_r == bfsm_pkg::IDX_LO)
                     link_nxt = bfsm_pkg::LK_SKIP;
                  else
                  begin
                     link_nxt = bfsm_pkg::LK_BYTE;
                     idx_nxt  = idx_r + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_r  <= bfsm_pkg::LK_IDLE;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         shift_r <= '0;
         bcnt_r  <= '0;
         idx_r   <= '0;
         cmd_r   <= '0;
         hi_r    <= '0;
         oe_r    <= 1'b0;
         // R3: default supply limit
         vlim_r  <= bfsm_pkg::VOLT_LIMIT_MV;
         // R4: default temperature limit
         tlim_r  <= bfsm_pkg::TEMP_LIMIT_C;
      end
      else if (ce)
      begin
         link_r  <= link_nxt;
         scl_d_r <= scl_d_nxt;
         sda_d_r <= sda_d_nxt;
         shift_r <= shift_nxt;
         bcnt_r  <= bcnt_nxt;
         idx_r   <= idx_nxt;
         cmd_r   <= cmd_nxt;
         hi_r    <= hi_nxt;
         oe_r    <= oe_nxt;
         vlim_r  <= vlim_nxt;
         tlim_r  <= tlim_nxt;
      end
   end

   // Open-drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_r;

   // R3: supply trips below limit
   bfsm_limit_cmp #(.TRIP_BELOW(1'b1)) u_volt_cmp (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .sample_valid (volt_valid),
      .reading      (volt_mv),
      .limit        (vlim_r),
      .trip         (volt_trip)
   );

   // R4: temperature trips at limit
   bfsm_limit_cmp #(.TRIP_BELOW(1'b0)) u_temp_cmp (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .sample_valid (temp_valid),
      .reading      (temp_c),
      .limit        (tlim_r),
      .trip         (temp_trip)
   );

   always_comb
   begin
      mode_nxt   = mode_r;
      cnt_nxt    = cnt_r;
      blink_nxt  = blink_r;
      reboot_nxt = 1'b0;
      unique case (mode_r)
         bfsm_pkg::ST_INIT:
         begin
            // R7: steady during initialisation
            blink_nxt = 1'b1;
            if (cnt_r == CNT_W'(INIT_CYCLES - 1))
            begin
               mode_nxt = bfsm_pkg::ST_RUN;
               cnt_nxt  = '0;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         bfsm_pkg::ST_RUN:
         begin
            // R7: blink while running
            if (cnt_r == CNT_W'(BLINK_CYCLES - 1))
            begin
               cnt_nxt   = '0;
               blink_nxt = ~blink_r;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         bfsm_pkg::ST_FAULT:
         begin
            // R10: no way out but reset
            blink_nxt = 1'b0;
         end
         default:
         begin
            mode_nxt = bfsm_pkg::ST_FAULT;
         end
      endcase
      // R1: trip in any live state
      if (mode_r != bfsm_pkg::ST_FAULT && (volt_trip || temp_trip))
      begin
         mode_nxt   = bfsm_pkg::ST_FAULT;
         reboot_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_r   <= bfsm_pkg::ST_INIT;
         cnt_r    <= '0;
         blink_r  <= 1'b1;
         reboot_r <= 1'b0;
      end
      else if (ce)
      begin
         mode_r   <= mode_nxt;
         cnt_r    <= cnt_nxt;
         blink_r  <= blink_nxt;
         reboot_r <= reboot_nxt;
      end
   end

   // R1: power removed on fault
   assign board_pwr_en    = (mode_r != bfsm_pkg::ST_FAULT);
   assign host_reboot_req = reboot_r;
   // R8: red steady in fault
   assign led_red         = (mode_r == bfsm_pkg::ST_FAULT);
   // R9: green never with red
   assign led_green       = blink_r & (mode_r != bfsm_pkg::ST_FAULT);

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_trip_seen;
      ce && mode_r != bfsm_pkg::ST_FAULT && (volt_trip || temp_trip);
   endsequence
   sequence s_shutdown;
      mode_r == bfsm_pkg::ST_FAULT && !board_pwr_en && host_reboot_req;
   endsequence

   AST_TRIP_SHUTDOWN: assert property (s_trip_seen |=> s_shutdown) // R1
      else $error("Trip did not shut down and request reboot");
   AST_REBOOT_ONCE: assert property (host_reboot_req && ce |=> !host_reboot_req) // R1
      else $error("Reboot request longer than one cycle");
   AST_LATCH: assert property (mode_r == bfsm_pkg::ST_FAULT |=> mode_r == bfsm_pkg::ST_FAULT && !board_pwr_en) // R10
      else $error("Fault state left without reset");
   AST_RED_FAULT: assert property (led_red == !board_pwr_en) // R8
      else $error("Red LED does not follow power hold-off");
   AST_ONE_LED: assert property (!(led_red && led_green) && (led_red || mode_r != bfsm_pkg::ST_FAULT)) // R9
      else $error("Indicator selection not exclusive");
   AST_INIT_STEADY: assert property (mode_r == bfsm_pkg::ST_INIT |-> led_green) // R7
      else $error("Green not steady during init");
   AST_BLINK: assert property (ce && mode_r == bfsm_pkg::ST_RUN && cnt_r == CNT_W'(BLINK_CYCLES - 1) // R7
                                && !volt_trip && !temp_trip |=> led_green != $past(led_green))
      else $error("Green failed to toggle at blink period");
   AST_ADDR_NACK: assert property (ce && link_r == bfsm_pkg::LK_BYTE && idx_r == bfsm_pkg::IDX_ADDR && scl_fall // R6
                                   && bcnt_r == bfsm_pkg::BITS_PER_BYTE && shift_r != bfsm_pkg::TARGET_ADDR
                                   && !start_c && !stop_c |=> !sda_oe)
      else $error("Acknowledged a foreign address");
   AST_LIMIT_WRITE: assert property (ce && link_r == bfsm_pkg::LK_BYTE && idx_r == bfsm_pkg::IDX_LO && scl_fall // R5
                                     && bcnt_r == bfsm_pkg::BITS_PER_BYTE && cmd_r == bfsm_pkg::CMD_SET_TEMP
                                     && !start_c && !stop_c |=> tlim_r == {$past(hi_r), $past(shift_r)})
      else $error("Temperature limit not updated");
   AST_NO_WARN_TRIP: assert property (ce && !(temp_valid && temp_c >= tlim_r) // R2
                                      && !(volt_valid && volt_mv < vlim_r) |=> !temp_trip && !volt_trip)
      else $error("Trip below nonrecoverable limit");
endmodule // bfsm_top

// ==== test_board_fault_shutdown_monitor.sv ====
/*
   Self-checking bench for the shutdown monitor: random and corner readings, limit
   rewrites over the link, LED timing. Assumes shortened init and blink counts.
*/
module test_board_fault_shutdown_monitor;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned INIT_N  = 20;
   localparam int unsigned BLINK_N = 8;

   logic        clk, sys_rst, ce, volt_valid, temp_valid, scl, sda_low, sda_in, sda_out, sda_oe;
   logic        board_pwr_en, host_reboot_req, led_green, led_red, prev;
   logic [15:0] volt_mv, temp_c;
   logic [31:0] seed;
   logic [3:0]  acks;
   int          n_fail, samples_checked, toggles, last;

   // Wired-and with pull-up: any party pulling wins
   assign sda_in = ~sda_low & ~(sda_oe & ~sda_out);

   bfsm_top #(.INIT_CYCLES(INIT_N), .BLINK_CYCLES(BLINK_N)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .volt_valid(volt_valid), .volt_mv(volt_mv),
      .temp_valid(temp_valid), .temp_c(temp_c), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .board_pwr_en(board_pwr_en), .host_reboot_req(host_reboot_req),
      .led_green(led_green), .led_red(led_red));

   bfsm_host_model #(.HALF(4)) host_u (.clk(clk), .sda_lvl(sda_in), .scl(scl), .sda_low(sda_low));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic check_acks(input logic [3:0] got, input logic [3:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t %s acks %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic do_reset;
      sys_rst = 1'b1;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
   endtask

   task automatic put_reading(input logic is_temp, input logic [15:0] val, input logic en);
      @(negedge clk);
      ce         = en;
      volt_valid = ~is_temp;
      temp_valid = is_temp;
      if (is_temp)
         temp_c = val;
      else
         volt_mv = val;
      @(negedge clk);
      volt_valid = 1'b0;
      temp_valid = 1'b0;
      ce         = 1'b1;
   endtask

   // Fault outputs land two edges after the sample, pulse lasts one cycle
   task automatic expect_trip(input logic exp);
      check_bit(board_pwr_en, 1'b1, "power off too early");
      @(negedge clk);
      check_bit(board_pwr_en, ~exp, "power enable");
      check_bit(host_reboot_req, exp, "reboot request");
      check_bit(led_red, exp, "red led");
      if (exp)
         check_bit(led_green, 1'b0, "green led in fault");
      @(negedge clk);
      check_bit(host_reboot_req, 1'b0, "reboot pulse width");
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   initial
   begin
      #200us;
      n_fail++;
      $display("[FAIL] %0t run timed out", $time);
      wrap_up();
   end

   // Never both indicators lit
   always @(negedge clk)
      check_bit(led_red & led_green, 1'b0, "both leds lit");

   initial
   begin
      sys_rst = 1'b1;
      ce = 1'b1;
      volt_valid = 1'b0;
      temp_valid = 1'b0;
      volt_mv = 16'h2ee0;
      temp_c = 16'h0019;
      seed = 32'he6e3;
      n_fail = 0;
      samples_checked = 0;
      do_reset();
      repeat (INIT_N - 2) begin @(negedge clk); check_bit(led_green, 1'b1, "green init"); end
      toggles = 0;
      last = -1;
      prev = led_green;
      for (int cyc = 0; cyc < 48; cyc++)
      begin
         @(negedge clk);
         if (led_green !== prev)
         begin
            if (last >= 0)
               check_bit(cyc - last == BLINK_N, 1'b1, "blink half period");
            last = cyc;
            toggles++;
         end
         prev = led_green;
      end
      check_bit(toggles >= 4, 1'b1, "green not blinking");
      $display("test leds done");
      for (int i = 0; i < 60; i++)
      begin
         seed = lfsr_next(seed);
         put_reading(seed[0], seed[0] ? 16'(seed[15:1] % 100) : 16'(16'h28dc + seed[12:1]), 1'b1);
         expect_trip(1'b0);
      end
      put_reading(1'b0, 16'h28dc, 1'b1);
      expect_trip(1'b0);
      put_reading(1'b1, 16'h0063, 1'b1);
      expect_trip(1'b0);
      // Clock enable low must hide the sample
      put_reading(1'b0, 16'h0000, 1'b0);
      expect_trip(1'b0);
      $display("test safe readings done");
      put_reading(1'b0, 16'h28db, 1'b1);
      expect_trip(1'b1);
      repeat (10) begin seed = lfsr_next(seed); put_reading(1'b1, 16'(seed[6:1]), 1'b1); end
      check_bit(board_pwr_en, 1'b0, "fault not latched");
      check_bit(led_red, 1'b1, "red not latched");
      $display("test voltage trip done");
      do_reset();
      put_reading(1'b1, 16'h0064, 1'b1);
      expect_trip(1'b1);
      $display("test temperature trip done");
      do_reset();
      host_u.write_frame(8'hcc, 8'h02, 16'h005a, acks);
      check_acks(acks, 4'h0, "foreign address");
      put_reading(1'b1, 16'h005f, 1'b1);
      expect_trip(1'b0);
      host_u.write_frame(8'hce, 8'h02, 16'h005a, acks);
      check_acks(acks, 4'hf, "temperature limit frame");
      put_reading(1'b1, 16'h0059, 1'b1);
      expect_trip(1'b0);
      put_reading(1'b1, 16'h005a, 1'b1);
      expect_trip(1'b1);
      $display("test temperature rewrite done");
      do_reset();
      host_u.write_frame(8'hce, 8'h07, 16'h2af8, acks);
      check_acks(acks, 4'h8, "unknown command");
      host_u.write_frame(8'hce, 8'h01, 16'h2af8, acks);
      check_acks(acks, 4'hf, "voltage limit frame");
      put_reading(1'b0, 16'h2a94, 1'b1);
      expect_trip(1'b1);
      $display("test voltage rewrite done");
      wrap_up();
   end
endmodule // test_board_fault_shutdown_monitor
